// File: verilog/ahp_host_port.sv
// Asynchronous 8-bit host port with indirect register access and code FIFO
`timescale 1ns/10ps
module ahp_host_port
    import ahp_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic host_cs_n_in,
    input wire logic [1:0] host_addr_in,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_out,
    output logic host_ack_n_out,
    input wire logic [7:0] code_bus_in,
    output logic [7:0] code_bus_out,
    output logic code_bus_oe_out,
    input wire logic code_slave_in,
    input wire logic wide_code_select_in,
    input wire logic compress_in,
    output logic fifo_wait_flag_out,
    input wire logic src_valid_in,
    input wire logic [15:0] src_data_in,
    output logic src_ready_out,
    output logic snk_valid_out,
    output logic [15:0] snk_data_out,
    input wire logic snk_ready_in,
    output logic [9:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in
);
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] filt;
        ahp_hstate_type state;
        logic op_rd;
        logic [1:0] addr;
        logic [PTR_W-1:0] ptr;
        logic [CODE_W-1:0] rdata;
        logic [BYTE_W-1:0] wdata;
        logic drive;
        logic wide;
        logic ack;
        logic reg_wr;
        logic reg_rd;
    } ahp_port_state_type;

    ahp_port_state_type cur_q;
    ahp_port_state_type nxt_d;
    ahp_buf_if #(.WIDTH(CODE_W)) bif ();

    logic rd_act;
    logic wr_act;
    logic cs_act;
    logic [1:0] pin_addr;
    logic [BYTE_W-1:0] pin_data;
    logic [BYTE_W-1:0] pin_code;
    logic [CODE_W-1:0] host_word;
    logic host_push;
    logic host_pop;
    logic code_acc;
    logic released;

    // Buffer stands between the compressor core and the host side
    ahp_code_buffer #(.WIDTH(CODE_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .bus(bif.store)
    );

    // Filtered pin levels; the strobes and select are active low
    assign rd_act = !cur_q.filt[PIN_RD];
    assign wr_act = !cur_q.filt[PIN_WR];
    assign cs_act = !cur_q.filt[PIN_CS];
    assign pin_addr = cur_q.filt[PIN_ADDR_LSB +: 2];
    assign pin_data = cur_q.filt[PIN_DATA_LSB +: BYTE_W];
    assign pin_code = cur_q.filt[PIN_CODE_LSB +: BYTE_W];
    assign code_acc = code_slave_in && cur_q.addr == ADDR_CODE;
    assign released = cur_q.op_rd ? !rd_act : !wr_act;

    // Narrow mode ignores the code byte lane entirely
    assign host_word = {wide_code_select_in ? pin_code : 8'h00, pin_data};

    // Buffer direction follows compression or decompression
    assign bif.in_valid = compress_in ? src_valid_in : host_push;
    assign bif.in_data = compress_in ? src_data_in : host_word;
    assign bif.out_ready = compress_in ? host_pop : snk_ready_in;
    assign src_ready_out = compress_in && bif.in_ready;
    assign snk_valid_out = !compress_in && bif.out_valid;
    assign snk_data_out = bif.out_data;
    // Wait flag: empty while compressing, full while decompressing
    assign fifo_wait_flag_out = code_slave_in &&
        (compress_in ? !bif.out_valid : !bif.in_ready);

    // Outputs are gated by select so a dropped select frees the bus at once
    assign host_ack_n_out = !(cur_q.ack && cs_act);
    assign host_data_oe_out = cur_q.drive && cs_act;
    assign code_bus_oe_out = cur_q.drive && cur_q.wide && cs_act;
    assign host_data_out = cur_q.rdata[7:0];
    assign code_bus_out = cur_q.rdata[15:8];
    assign reg_addr_out = cur_q.ptr;
    assign reg_wdata_out = cur_q.wdata;
    assign reg_wr_out = cur_q.reg_wr;
    assign reg_rd_out = cur_q.reg_rd;

    // Synchronisers and the access sequencer
    always_comb begin
        nxt_d = cur_q;
        host_push = 1'b0;
        host_pop = 1'b0;
        // Three stages; a level counts once the last two agree
        nxt_d.s1 = {code_bus_in, host_data_in, host_addr_in,
                    host_cs_n_in, host_wr_n_in, host_rd_n_in};
        nxt_d.s2 = cur_q.s1;
        nxt_d.s3 = cur_q.s2;
        nxt_d.filt = (~(cur_q.s2 ^ cur_q.s3) & cur_q.s3) |
                     ((cur_q.s2 ^ cur_q.s3) & cur_q.filt);
        nxt_d.reg_wr = 1'b0;
        nxt_d.reg_rd = 1'b0;
        case (cur_q.state)
            HS_IDLE: begin
                nxt_d.drive = 1'b0;
                nxt_d.ack = 1'b0;
                // Both strobes at once is not an access
                if (cs_act && (rd_act ^ wr_act)) begin
                    nxt_d.op_rd = rd_act;
                    nxt_d.addr = pin_addr;
                    nxt_d.state = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (!cs_act || !(rd_act || wr_act)) begin
                    nxt_d.state = HS_IDLE;
                end else if (code_acc && cur_q.op_rd && compress_in) begin
                    // Held off until a word is there to give
                    if (bif.out_valid) begin
                        host_pop = 1'b1;
                        nxt_d.rdata = wide_code_select_in ? bif.out_data
                                                          : {8'h00, bif.out_data[7:0]};
                        nxt_d.wide = wide_code_select_in;
                        nxt_d.drive = 1'b1;
                        nxt_d.ack = 1'b1;
                        nxt_d.state = HS_ACK;
                    end
                end else if (code_acc && !cur_q.op_rd && !compress_in) begin
                    // Held off until there is room for the word
                    if (bif.in_ready) begin
                        nxt_d.ack = 1'b1;
                        nxt_d.state = HS_ACK;
                    end
                end else if (cur_q.op_rd && cur_q.addr == ADDR_DATA) begin
                    nxt_d.reg_rd = 1'b1;
                    nxt_d.state = HS_FETCH;
                end else begin
                    // Pointer access, data write, wrong-direction code or master-mode address 0
                    if (cur_q.addr == ADDR_PTR_LO) begin
                        nxt_d.rdata = {8'h00, cur_q.ptr[7:0]};
                    end else if (cur_q.addr == ADDR_PTR_HI) begin
                        nxt_d.rdata = {14'h0000, cur_q.ptr[9:8]};
                    end else begin
                        nxt_d.rdata = 16'h0000;
                    end
                    nxt_d.wide = 1'b0;
                    nxt_d.drive = cur_q.op_rd;
                    nxt_d.ack = 1'b1;
                    nxt_d.state = HS_ACK;
                end
            end
            HS_FETCH: begin
                // Register space answers during the read pulse
                nxt_d.rdata = {8'h00, reg_rdata_in};
                nxt_d.wide = 1'b0;
                nxt_d.drive = 1'b1;
                nxt_d.ack = 1'b1;
                nxt_d.state = HS_ACK;
            end
            HS_ACK: begin
                if (!cs_act) begin
                    // Select lost mid-access: abandon; no write is committed, but a code read has already popped its word
                    nxt_d.ack = 1'b0;
                    nxt_d.drive = 1'b0;
                    nxt_d.state = HS_IDLE;
                end else if (released) begin
                    nxt_d.ack = 1'b0;
                    nxt_d.drive = 1'b0;
                    nxt_d.state = HS_DONE;
                    if (!cur_q.op_rd) begin
                        // Data taken as it stands when the strobe rises
                        if (cur_q.addr == ADDR_CODE) begin
                            host_push = code_slave_in && !compress_in;
                        end else if (cur_q.addr == ADDR_DATA) begin
                            nxt_d.reg_wr = 1'b1;
                            nxt_d.wdata = pin_data;
                        end else if (cur_q.addr == ADDR_PTR_LO) begin
                            // Only a host pointer write moves the pointer
                            nxt_d.ptr[7:0] = pin_data;
                        end else begin
                            nxt_d.ptr[9:8] = pin_data[1:0];
                        end
                    end
                end
            end
            HS_DONE: begin
                nxt_d.state = HS_IDLE;
            end
            default: begin
                nxt_d.state = HS_IDLE;
            end
        endcase
    end

    // State register; pins reset to their idle levels
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cur_q <= '0;
            cur_q.s1 <= PIN_IDLE;
            cur_q.s2 <= PIN_IDLE;
            cur_q.s3 <= PIN_IDLE;
            cur_q.filt <= PIN_IDLE;
            cur_q.ptr <= PTR_RESET;
            cur_q.state <= HS_IDLE;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // Checks on the sequencer
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    idle_bus_off_a: assert property (!cs_act |-> host_ack_n_out && !host_data_oe_out)
        else $error("ack or data driven without select");
    ack_after_strobe_a: assert property ($rose(cur_q.ack) |-> $past(rd_act || wr_act))
        else $error("ack raised without a strobe");
    ack_release_a: assert property (cur_q.state == HS_ACK && released && cs_act
        |=> !cur_q.ack ##1 cur_q.state == HS_IDLE)
        else $error("ack not released after strobe release");
    read_drive_a: assert property (cur_q.ack && cur_q.op_rd && cs_act
        |-> host_data_oe_out)
        else $error("read data not driven while acknowledged");
    ptr_stable_a: assert property (!(cur_q.state == HS_ACK && !cur_q.op_rd
        && cur_q.addr[1]) |=> $stable(cur_q.ptr))
        else $error("pointer moved without a pointer write");
    ptr_low_only_a: assert property (cur_q.state == HS_ACK && released && cs_act
        && !cur_q.op_rd && cur_q.addr == ADDR_PTR_LO
        |=> cur_q.ptr[9:8] == $past(cur_q.ptr[9:8]) && cur_q.ptr[7:0] == $past(pin_data))
        else $error("low pointer write disturbed high byte");
    write_capture_a: assert property (cur_q.state == HS_ACK && released && cs_act
        && !cur_q.op_rd && cur_q.addr == ADDR_DATA
        |=> reg_wr_out && reg_wdata_out == $past(pin_data) ##1 !reg_wr_out)
        else $error("data write not committed at strobe rise");
    code_wait_a: assert property ($rose(cur_q.ack) && code_slave_in && cur_q.addr == ADDR_CODE
        && compress_in && cur_q.op_rd |-> $past(bif.out_valid))
        else $error("code read acknowledged while buffer empty");
    master_no_code_a: assert property (!code_slave_in |-> !host_push && !host_pop)
        else $error("code buffer touched outside slave mode");
    narrow_word_a: assert property (host_push && !wide_code_select_in
        |-> bif.in_data[15:8] == 8'h00)
        else $error("narrow code word carries a high byte");
    sync_agree_a: assert property (cur_q.s2[PIN_RD] == cur_q.s3[PIN_RD]
        |=> cur_q.filt[PIN_RD] == $past(cur_q.s3[PIN_RD]))
        else $error("strobe filter did not follow agreeing stages");
    // Held read data, hold-off paths, the high pointer write and the register read pulse
    read_hold_a: assert property (cur_q.state == HS_ACK && cs_act && !released
        |=> cur_q.ack && $stable(cur_q.rdata))
        else $error("acknowledged data moved before strobe release");
    code_room_a: assert property ($rose(cur_q.ack) && code_acc && !cur_q.op_rd
        && !compress_in |-> $past(bif.in_ready))
        else $error("code write acknowledged while buffer full");
    ptr_high_only_a: assert property (cur_q.state == HS_ACK && released && cs_act
        && !cur_q.op_rd && cur_q.addr == ADDR_PTR_HI
        |=> cur_q.ptr[7:0] == $past(cur_q.ptr[7:0]) && cur_q.ptr[9:8] == $past(pin_data[1:0]))
        else $error("high pointer write disturbed low byte");
    fetch_pulse_a: assert property (reg_rd_out
        |-> cur_q.state == HS_FETCH && cur_q.op_rd)
        else $error("register read pulse outside a data read");
    wait_clear_a: assert property (code_slave_in && compress_in && bif.out_valid
        |-> !fifo_wait_flag_out)
        else $error("wait flag raised with a word to give");
endmodule

// File: verilog/ahp_pkg.sv
// Shared constants and types for the asynchronous host register port
package ahp_pkg;
    // Direct-access locations selected by the 2-bit address
    localparam logic [1:0] ADDR_CODE = 2'h0;
    localparam logic [1:0] ADDR_DATA = 2'h1;
    localparam logic [1:0] ADDR_PTR_LO = 2'h2;
    localparam logic [1:0] ADDR_PTR_HI = 2'h3;
    // Widths of the host byte, the pointer and the code word, then the buffer depth and pointer reset value
    localparam int BYTE_W = 8;
    localparam int PTR_W = 10;
    localparam int CODE_W = 16;
    localparam int BUF_DEPTH = 2;
    localparam logic [PTR_W-1:0] PTR_RESET = 10'h000;
    // Field positions of the sampled pin vector
    localparam int PIN_RD = 0;
    localparam int PIN_WR = 1;
    localparam int PIN_CS = 2;
    localparam int PIN_ADDR_LSB = 3;
    localparam int PIN_DATA_LSB = 5;
    localparam int PIN_CODE_LSB = 13;
    localparam int PIN_W = 21;
    // Strobes and select idle high
    localparam logic [PIN_W-1:0] PIN_IDLE = 21'h000007;
    localparam int CLOCK_PERIOD_NS = 5;
    // Handshake sequencer states
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_WAIT = 3'b001,
        HS_FETCH = 3'b010,
        HS_ACK = 3'b011,
        HS_DONE = 3'b100
    } ahp_hstate_type;
endpackage

// File: verilog/ahp_buf_if.sv
// Valid/ready carrier between the port sequencer and its code buffer
`timescale 1ns/10ps
interface ahp_buf_if #(parameter int WIDTH = 16);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
    modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// File: verilog/ahp_code_buffer.sv
// Small code word buffer with valid and ready on both sides
`timescale 1ns/10ps
module ahp_code_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic clock_in,
    input wire logic reset_in,
    ahp_buf_if.store bus
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointer arithmetic wraps, so only powers of two are served
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("ahp_code_buffer: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } ahp_buf_state_type;

    ahp_buf_state_type cur_q;
    ahp_buf_state_type nxt_d;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count
    assign bus.in_ready = cur_q.count != DEPTH[AW:0];
    assign bus.out_valid = cur_q.count != '0;
    assign bus.out_data = cur_q.mem[cur_q.rd_ptr];

    // Next state: write at the tail, read at the head
    always_comb begin
        nxt_d = cur_q;
        push = bus.in_valid && bus.in_ready;
        pop = bus.out_valid && bus.out_ready;
        if (push) begin
            nxt_d.mem[cur_q.wr_ptr] = bus.in_data;
            nxt_d.wr_ptr = cur_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_d.rd_ptr = cur_q.rd_ptr + 1'b1;
        end
        nxt_d.count = cur_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end
endmodule

// File: verification/ahp_host_model.sv
// Host processor model driving the asynchronous port strobes
`timescale 1ns/10ps
module ahp_host_model (
    input wire logic clock_in,
    input wire logic ack_n_in,
    input wire logic [15:0] bus_in,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic cs_n_out,
    output logic [1:0] addr_out,
    output logic [15:0] wdata_out,
    output logic drive_out
);
    // Idle host: strobes and select high, bus not driven
    initial begin
        {rd_n_out, wr_n_out, cs_n_out, drive_out} = 4'he;
        addr_out = 2'h0;
        wdata_out = 16'h0000;
    end

    // One complete strobe cycle; select dropped after each one
    task automatic access(input logic rd, input logic [1:0] a, input logic [15:0] d,
            output logic [15:0] q, output logic ok);
        int n;
        n = 0;
        @(negedge clock_in);
        cs_n_out = 1'b0;
        addr_out = a;
        wdata_out = d;
        drive_out = ~rd;
        rd_n_out = ~rd;
        wr_n_out = rd;
        // Acknowledge is never ignored, so no strobe width is assumed
        // Strobe stays low until acknowledge is seen at an edge, for at most 400 edges
        do begin
            @(posedge clock_in);
            n++;
        end while (ack_n_in !== 1'b0 && n < 400);
        q = bus_in;
        ok = (n < 400);
        n = 0;
        @(negedge clock_in);
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        // Data and select held until acknowledge is released
        do begin
            @(posedge clock_in);
            n++;
        end while (ack_n_in !== 1'b1 && n < 400);
        ok = ok && (n < 400);
        @(negedge clock_in);
        cs_n_out = 1'b1;
        drive_out = 1'b0;
    endtask
endmodule

// File: verification/test_async_host_register_port.sv
// Self-checking bench for the asynchronous host register port
`timescale 1ns/10ps
module test_async_host_register_port;
    import ahp_pkg::*;
    typedef struct {logic rd; logic [1:0] a; logic [7:0] d; logic [7:0] e;} ahp_row_type;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic rd_n, wr_n, cs_n, drive, hoe, coe, ack_n, wflag, src_ready, snk_valid, reg_wr, reg_rd;
    logic slave = 1'b0, wide = 1'b0, comp = 1'b0, src_valid = 1'b0, snk_ready = 1'b0;
    logic [1:0] addr;
    logic [7:0] hout, cout, reg_wdata, float_v = 8'h55;
    logic [15:0] hw, bus, dq, snk_data, src_data = 16'h0000;
    logic [9:0] reg_addr;
    logic [7:0] mem [1024];
    logic [15:0] snk_q[$];
    int num_errors = 0;
    int checked = 0;
    // Pointer, data, readback and refused code read in master mode
    ahp_row_type rows[13] = '{'{0, ADDR_PTR_LO, 8'h34, 8'h00}, '{0, ADDR_PTR_HI, 8'h02, 8'h00},
        '{0, ADDR_DATA, 8'ha5, 8'h00}, '{1, ADDR_DATA, 8'h00, 8'ha5}, '{1, ADDR_DATA, 8'h00, 8'ha5},
        '{0, ADDR_PTR_HI, 8'h01, 8'h00}, '{0, ADDR_DATA, 8'h5a, 8'h00}, '{1, ADDR_PTR_LO, 8'h00, 8'h34},
        '{1, ADDR_PTR_HI, 8'h00, 8'h01}, '{1, ADDR_DATA, 8'h00, 8'h5a}, '{0, ADDR_PTR_HI, 8'h02, 8'h00},
        '{1, ADDR_DATA, 8'h00, 8'ha5}, '{1, ADDR_CODE, 8'h00, 8'h00}};

    always #2.5 clock_in = ~clock_in;
    // Released lines show a changing pattern, never the last value
    always @(posedge clock_in) float_v <= ~float_v;
    assign bus[7:0] = hoe ? hout : (drive ? hw[7:0] : float_v);
    assign bus[15:8] = coe ? cout : (drive ? hw[15:8] : ~float_v);
    // Internal register space answers in the read cycle
    always @(posedge clock_in) if (reg_wr) mem[reg_addr] <= reg_wdata;
    always @(posedge clock_in) if (snk_valid && snk_ready) snk_q.push_back(snk_data);

    ahp_host_port dut_u (.clock_in(clock_in), .reset_in(reset_in), .host_rd_n_in(rd_n),
        .host_wr_n_in(wr_n), .host_cs_n_in(cs_n), .host_addr_in(addr), .host_data_in(bus[7:0]),
        .host_data_out(hout), .host_data_oe_out(hoe), .host_ack_n_out(ack_n),
        .code_bus_in(bus[15:8]), .code_bus_out(cout), .code_bus_oe_out(coe),
        .code_slave_in(slave), .wide_code_select_in(wide), .compress_in(comp),
        .fifo_wait_flag_out(wflag), .src_valid_in(src_valid), .src_data_in(src_data),
        .src_ready_out(src_ready), .snk_valid_out(snk_valid), .snk_data_out(snk_data),
        .snk_ready_in(snk_ready), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
        .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_rdata_in(reg_rd ? mem[reg_addr] : 8'hee));
    ahp_host_model host_u (.clock_in(clock_in), .ack_n_in(ack_n), .bus_in(bus),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .cs_n_out(cs_n), .addr_out(addr), .wdata_out(hw),
        .drive_out(drive));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A strobe cycle that never completes ends the run
    task automatic op(input logic rd, input logic [1:0] a, input logic [15:0] d);
        logic ok;
        host_u.access(rd, a, d, dq, ok);
        if (!ok) begin
            chk(16'(ack_n), 16'h0);
            end_sim();
        end
    endtask

    // Valid held until the rising edge that sees ready, dropped after it
    task automatic push(input logic [15:0] w);
        int n;
        n = 0;
        @(negedge clock_in);
        src_valid = 1'b1;
        src_data = w;
        do begin
            @(posedge clock_in);
            n++;
        end while (src_ready !== 1'b1 && n < 100);
        @(negedge clock_in);
        src_valid = 1'b0;
        chk(16'(n < 100), 16'h1);
    endtask

    // Slow waits are a stall; the port must hold off acknowledge
    task automatic stall_chk();
        repeat (40) @(negedge clock_in);
        chk(16'({ack_n, wflag}), 16'h3);
    endtask

    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        #100000;
        chk(16'h0, 16'h1);
        end_sim();
    end

    initial begin
        // Clock runs before any access is made
        repeat (20) @(negedge clock_in);
        reset_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk({5'h0, ack_n, hoe, coe, reg_wr, reg_rd, reg_addr[5:0]}, 16'h0400);
        $display("reset test done");
        foreach (rows[i]) begin
            op(rows[i].rd, rows[i].a, {8'h00, rows[i].d});
            if (rows[i].rd) chk(16'(dq[7:0]), 16'(rows[i].e));
        end
        chk(16'(reg_addr), 16'h0234);
        chk(16'(mem[10'h134]), 16'h005a);
        $display("register test done");
        // Slave decompression, 16-bit words, sink stalled until full
        @(negedge clock_in);
        {slave, wide, comp} = 3'b110;
        op(0, ADDR_CODE, 16'hbeef);
        op(0, ADDR_CODE, 16'h1234);
        fork
            op(0, ADDR_CODE, 16'h5678);
            begin
                stall_chk();
                snk_ready = 1'b1;
            end
        join
        repeat (20) @(negedge clock_in);
        chk(16'(snk_q.size()), 16'h3);
        while (snk_q.size() < 3) snk_q.push_back(16'h0);
        chk(snk_q[0], 16'hbeef);
        chk(snk_q[1], 16'h1234);
        chk(snk_q[2], 16'h5678);
        $display("decompress test done");
        // Slave compression, 8-bit reads, then an empty-buffer stall
        {wide, comp} = 2'b01;
        push(16'h11c3);
        push(16'h22d4);
        chk(16'(src_ready), 16'h0);
        op(1, ADDR_CODE, 16'h0);
        chk(16'(dq[7:0]), 16'h00c3);
        op(1, ADDR_CODE, 16'h0);
        chk(16'(dq[7:0]), 16'h00d4);
        @(negedge clock_in);
        wide = 1'b1;
        fork
            op(1, ADDR_CODE, 16'h0);
            begin
                stall_chk();
                push(16'hab77);
            end
        join
        chk(dq, 16'hab77);
        $display("compress test done");
        // Narrow decompression write drops the code byte lane
        @(negedge clock_in);
        {wide, comp} = 2'b00;
        op(0, ADDR_CODE, 16'h77c5);
        repeat (4) @(negedge clock_in);
        chk(16'(snk_q.size()), 16'h4);
        chk(snk_q[$], 16'h00c5);
        // Reset in mid-run returns the pointer and frees the port
        reset_in = 1'b1;
        repeat (4) @(negedge clock_in);
        reset_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk({4'h0, ack_n, hoe, reg_addr}, {4'h0, 1'b1, 1'b0, PTR_RESET});
        $display("narrow and reset tests done");
        end_sim();
    end
endmodule
